// [design/mbs_pkg.sv]
// Package of constants and types for the multiphase buck sequencer
// ****************************************************************
// Behaviour
// - Four states; idle until enable asserted
// - Dead-time forces comparator high 1.6 ms
// - Bypass goes straight from idle to run
// - Bypass from pin or configuration bit
// - Soft-start gates pulses with DDS ramp
// - Ramp starts at configured increment, rises
// - Accumulator, increment reset on soft-start entry
// - Soft-start request low moves to run
// - Soft-start-active only in soft-start
// - Soft-start-done only in run
// - Comparator force only in dead-time
// - Phase field 0..7 gives 1..8 phases
// - Round-robin one-hot over enabled phases
// - Eight phase drives with output enables
// - Forced mode pulses, else static drive in run
// - Forced-mode pin high in run only
// - Unused phases driven low when configured
// - 38-bit serial configuration register
// - Debug mux routes internal signals
// - Enable low returns idle, clears dead-time count, DDS ramp and phase
// ****************************************************************
package mbs_pkg;

  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned DEADTIME_US    = 1600;
  localparam int unsigned DEADTIME_CYC   = DEADTIME_US * CLK_MHZ;
  localparam int unsigned CFG_W          = 38;
  localparam int unsigned NPH            = 8;
  localparam int unsigned DDS_W          = 16;
  localparam int unsigned RAMP_DIV_W     = 12;

  // Configuration field positions
  localparam int unsigned F_BYPASS       = 0;
  localparam int unsigned F_EXTREF       = 1;
  localparam int unsigned F_SSINC        = 2;
  localparam int unsigned F_SSINC_W      = 8;
  localparam int unsigned F_TON          = 10;
  localparam int unsigned F_TON_W        = 4;
  localparam int unsigned F_NPH          = 14;
  localparam int unsigned F_NPH_W        = 3;
  localparam int unsigned F_REFTRIM      = 17;
  localparam int unsigned F_REFTRIM_W    = 8;
  localparam int unsigned F_REFSEL       = 25;
  localparam int unsigned F_EXTCAP       = 26;
  localparam int unsigned F_HIGHGM       = 27;
  localparam int unsigned F_FCCM         = 28;
  localparam int unsigned F_UNUSED_LOW   = 29;
  localparam int unsigned F_DBG          = 30;
  localparam int unsigned F_DBG_W        = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 38'h00_0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_DEADTIME = 2'b01,
    ST_SOFT     = 2'b10,
    ST_RUN      = 2'b11
  } mbs_state_t;

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] sdat_sync;
    logic [1:0] apply_sync;
    logic [1:0] en_sync;
    logic [1:0] byp_sync;
    logic [1:0] ss_req_sync;
    logic [1:0] cot_sync;
    logic       sclk_prev;
    logic       apply_prev;
    logic       cot_prev;
    logic [CFG_W-1:0] shift;
    logic [CFG_W-1:0] cfg;
    mbs_state_t state;
    logic [31:0] dt_cnt;
    logic [DDS_W-1:0] acc;
    logic [DDS_W-1:0] inc;
    logic [RAMP_DIV_W-1:0] ramp_div;
    logic       tick;
    logic [2:0] phase;
    logic       strobe;
    logic [NPH-1:0] drive;
    logic [3:0] dbg;
  } mbs_state_reg_t;

endpackage : mbs_pkg

// [design/mbs_top.sv]
// Digital sequencer of the multiphase buck converter controller
`timescale 1ns/1ps
module mbs_top (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  // Control pins
  input  wire logic             i_controller_enable,
  input  wire logic             i_bypass_pin,
  // Analog loop signals
  input  wire logic             i_switch_event,
  input  wire logic             i_softstart_request,
  // Serial configuration
  input  wire logic             i_cfg_serial_in,
  input  wire logic             i_cfg_serial_clock,
  input  wire logic             i_cfg_apply,
  output logic                  o_cfg_serial_out,
  // Status and analog controls
  output logic                  o_force_comp_high,
  output logic                  o_ss_active,
  output logic                  o_ss_done,
  output logic                  o_forced_cont_mode_out,
  output logic [3:0]            o_ton_sel,
  output logic                  o_ext_ref,
  output logic [7:0]            o_ref_trim,
  output logic                  o_ref_sel,
  output logic                  o_ext_cap,
  output logic                  o_high_gm,
  // Phase drives
  output logic [7:0]            o_phase_drive,
  output logic [7:0]            o_phase_drive_oe,
  output logic                  o_phase_strobe,
  // Debug
  output logic [3:0]            o_debug_out
);

  mbs_pkg::mbs_state_reg_t r;
  mbs_pkg::mbs_state_reg_t next_r;

  // ****************************************
  // Enabled phase mask
  // ****************************************
  function automatic logic [7:0] phase_mask(input logic [2:0] n);
    logic [7:0] m;
    m = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (3'(k) <= n) begin
        m[k] = 1'b1;
      end
    end
    return m;
  endfunction : phase_mask

  function automatic logic debug_pick(input logic [1:0] sel, input logic [7:0] v4);
    logic b;
    b = v4[{1'b0, sel} + 3'h0];
    return b;
  endfunction : debug_pick

  logic [2:0] nph;
  logic       bypass;
  logic       fccm;
  logic [7:0] mask;
  logic       sclk_rise;
  logic       apply_rise;
  logic       cot_rise;
  logic [mbs_pkg::DDS_W:0] acc_sum;
  logic       pulse_req;
  logic [7:0] onehot;
  logic [15:0] dbg_src;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    nph    = r.cfg[mbs_pkg::F_NPH +: mbs_pkg::F_NPH_W];
    fccm   = r.cfg[mbs_pkg::F_FCCM];
    mask   = phase_mask(nph);
    bypass = r.byp_sync[1] | r.cfg[mbs_pkg::F_BYPASS];
    next_r.sclk_sync   = {r.sclk_sync[0], i_cfg_serial_clock};
    next_r.sdat_sync   = {r.sdat_sync[0], i_cfg_serial_in};
    next_r.apply_sync  = {r.apply_sync[0], i_cfg_apply};
    next_r.en_sync     = {r.en_sync[0], i_controller_enable};
    next_r.byp_sync    = {r.byp_sync[0], i_bypass_pin};
    next_r.ss_req_sync = {r.ss_req_sync[0], i_softstart_request};
    next_r.cot_sync    = {r.cot_sync[0], i_switch_event};
    next_r.sclk_prev   = r.sclk_sync[1];
    next_r.apply_prev  = r.apply_sync[1];
    next_r.cot_prev    = r.cot_sync[1];
    sclk_rise  = r.sclk_sync[1] & ~r.sclk_prev;
    apply_rise = r.apply_sync[1] & ~r.apply_prev;
    cot_rise   = r.cot_sync[1] & ~r.cot_prev;

    // Serial configuration
    if (sclk_rise) begin
      next_r.shift = {r.shift[mbs_pkg::CFG_W-2:0], r.sdat_sync[1]};
    end
    if (apply_rise) begin
      next_r.cfg = r.shift;
    end

    // DDS ramp
    acc_sum      = {1'b0, r.acc} + {1'b0, r.inc};
    next_r.tick  = 1'b0;
    pulse_req    = 1'b0;
    next_r.strobe = 1'b0;
    next_r.ramp_div = r.ramp_div + 12'h001;

    case (r.state)
      mbs_pkg::ST_IDLE: begin
        next_r.dt_cnt = 32'h0000_0000;
        if (r.en_sync[1]) begin
          if (bypass) begin
            next_r.state = mbs_pkg::ST_RUN;
          end else begin
            next_r.state = mbs_pkg::ST_DEADTIME;
          end
        end
      end
      mbs_pkg::ST_DEADTIME: begin
        next_r.dt_cnt = r.dt_cnt + 32'h0000_0001;
        if (r.dt_cnt == 32'(mbs_pkg::DEADTIME_CYC - 1)) begin
          next_r.state    = mbs_pkg::ST_SOFT;
          next_r.acc      = 16'h0000;
          next_r.inc      = {8'h00, r.cfg[mbs_pkg::F_SSINC +: mbs_pkg::F_SSINC_W]};
          next_r.ramp_div = 12'h000;
        end
      end
      mbs_pkg::ST_SOFT: begin
        next_r.acc  = acc_sum[mbs_pkg::DDS_W-1:0];
        next_r.tick = acc_sum[mbs_pkg::DDS_W];
        pulse_req   = acc_sum[mbs_pkg::DDS_W];
        if (r.ramp_div == 12'hFFF && r.inc != 16'hFFFF) begin
          next_r.inc = r.inc + 16'h0001;
        end
        if (!r.ss_req_sync[1]) begin
          next_r.state = mbs_pkg::ST_RUN;
        end
      end
      mbs_pkg::ST_RUN: begin
        pulse_req = cot_rise;
      end
      default: begin
        next_r.state = mbs_pkg::ST_IDLE;
      end
    endcase

    // Phase rotation
    onehot = 8'h01 << r.phase;
    if (pulse_req) begin
      next_r.strobe = 1'b1;
      if (r.phase >= nph) begin
        next_r.phase = 3'h0;
      end else begin
        next_r.phase = r.phase + 3'h1;
      end
    end
    if (r.phase > nph) begin
      next_r.phase = 3'h0;
    end

    // Phase drive outputs
    if (fccm) begin
      next_r.drive = pulse_req ? onehot : 8'h00;
    end else if (r.state == mbs_pkg::ST_RUN) begin
      next_r.drive = mask;
    end else begin
      next_r.drive = pulse_req ? onehot : 8'h00;
    end
    if (r.cfg[mbs_pkg::F_UNUSED_LOW]) begin
      next_r.drive = next_r.drive & mask;
    end

    // Debug mux
    dbg_src = {r.strobe, r.tick, r.state == mbs_pkg::ST_RUN, r.state == mbs_pkg::ST_SOFT,
               r.state == mbs_pkg::ST_DEADTIME, r.state[1], r.state[0], r.ss_req_sync[1],
               r.cot_sync[1], r.en_sync[1], fccm, bypass,
               r.drive[3], r.drive[2], r.drive[1], r.drive[0]};
    for (int d = 0; d < 4; d++) begin
      next_r.dbg[d] = debug_pick(r.cfg[mbs_pkg::F_DBG + 2*d +: 2],
                                 dbg_src[4*d +: 8 - 4]
                                 == 4'h0 ? 8'h00 : {4'h0, dbg_src[4*d +: 4]});
    end

    // Disable returns to idle
    if (!r.en_sync[1]) begin
      next_r.state  = mbs_pkg::ST_IDLE;
      next_r.dt_cnt = 32'h0000_0000;
      next_r.acc    = 16'h0000;
      next_r.inc    = 16'h0000;
      next_r.phase  = 3'h0;
      next_r.strobe = 1'b0;
      next_r.tick   = 1'b0;
      next_r.drive  = 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      r       <= '0;
      r.cfg   <= mbs_pkg::CFG_RESET;
      r.state <= mbs_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_force_comp_high      = (r.state == mbs_pkg::ST_DEADTIME);
  assign o_ss_active            = (r.state == mbs_pkg::ST_SOFT);
  assign o_ss_done              = (r.state == mbs_pkg::ST_RUN);
  assign o_forced_cont_mode_out = (r.state == mbs_pkg::ST_RUN) & r.cfg[mbs_pkg::F_FCCM];
  assign o_cfg_serial_out       = r.shift[mbs_pkg::CFG_W-1];
  assign o_ton_sel              = r.cfg[mbs_pkg::F_TON +: mbs_pkg::F_TON_W];
  assign o_ext_ref              = r.cfg[mbs_pkg::F_EXTREF];
  assign o_ref_trim             = r.cfg[mbs_pkg::F_REFTRIM +: mbs_pkg::F_REFTRIM_W];
  assign o_ref_sel              = r.cfg[mbs_pkg::F_REFSEL];
  assign o_ext_cap              = r.cfg[mbs_pkg::F_EXTCAP];
  assign o_high_gm              = r.cfg[mbs_pkg::F_HIGHGM];
  assign o_phase_drive          = r.drive;
  assign o_phase_drive_oe       = 8'hFF;
  assign o_phase_strobe         = r.strobe;
  assign o_debug_out            = r.dbg;

endmodule : mbs_top

// [test/mbs_loop_model.sv]
// Behavioural model of the analog regulation loop
`timescale 1ns/1ps
module mbs_loop_model (
  // Clock and control
  input  wire logic i_clk,
  input  wire logic i_active,
  // Loop outputs
  output logic      o_switch_event,
  output logic      o_softstart_request
);
  int cnt = 0;
  initial o_switch_event = 1'b0;
  // Request held high: soft-start is never ended by the loop
  assign o_softstart_request = 1'b1;
  // Switching events every ten cycles, three cycles wide
  always @(negedge i_clk) begin
    cnt = i_active ? (cnt + 1) % 10 : 0;
    o_switch_event <= i_active && (cnt < 3);
  end
endmodule : mbs_loop_model

// [test/mbs_top_asserts.sv]
// Port assertions of the sequencer
`timescale 1ns/1ps
module mbs_top_asserts (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // Observed pins
  input  wire logic       i_controller_enable,
  input  wire logic       i_bypass_pin,
  input  wire logic       o_force_comp_high,
  input  wire logic       o_ss_active,
  input  wire logic       o_ss_done,
  input  wire logic       o_forced_cont_mode_out,
  input  wire logic [7:0] o_phase_drive_oe,
  input  wire logic       o_phase_strobe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_quiet;
    !i_controller_enable [*5];
  endsequence
  sequence s_byp_on;
    (i_controller_enable && i_bypass_pin) [*8];
  endsequence
  AST_ONE_STATE: assert property ($onehot0({o_force_comp_high, o_ss_active, o_ss_done}))
    else $error("state flags overlap");
  AST_DT_ENTRY: assert property ($rose(o_force_comp_high) |-> $past(!o_ss_active && !o_ss_done))
    else $error("dead-time not entered from idle");
  AST_DT_HOLD: assert property ($rose(o_force_comp_high) ##0 i_controller_enable [*8] |-> o_force_comp_high)
    else $error("dead-time left early");
  AST_BYP_RUN: assert property (s_quiet ##1 s_byp_on |-> o_ss_done && !o_force_comp_high)
    else $error("bypass did not reach run");
  AST_DISABLE: assert property (s_quiet |-> !o_ss_done && !o_ss_active && !o_force_comp_high)
    else $error("disable did not return to idle");
  AST_FCCM_RUN: assert property (o_forced_cont_mode_out |-> o_ss_done)
    else $error("forced mode outside run");
  AST_OE_ALL: assert property (o_phase_drive_oe == 8'hFF)
    else $error("phase output enable low");
  AST_STROBE: assert property (o_phase_strobe |=> !o_phase_strobe)
    else $error("strobe longer than one cycle");
endmodule : mbs_top_asserts
bind mbs_top mbs_top_asserts mbs_top_asserts_i (.i_clk(i_clk), .i_srst(i_srst),
  .i_controller_enable(i_controller_enable), .i_bypass_pin(i_bypass_pin),
  .o_force_comp_high(o_force_comp_high), .o_ss_active(o_ss_active), .o_ss_done(o_ss_done),
  .o_forced_cont_mode_out(o_forced_cont_mode_out), .o_phase_drive_oe(o_phase_drive_oe),
  .o_phase_strobe(o_phase_strobe));

// [test/multiphase_buck_sequencer_tb_top.sv]
// Self-checking bench of the multiphase buck sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module multiphase_buck_sequencer_tb_top;
  logic        i_clk = 1'b0, i_srst = 1'b1, en = 1'b0, byp = 1'b0;
  logic        sin = 1'b0, sclk = 1'b0, apply = 1'b0, act = 1'b0;
  logic        sw, ssreq, so, fch, ssa, ssd, fco, xref, rsel, xcap, hgm, strobe;
  logic [3:0]  ton, dbg;
  logic [7:0]  trim, drv, oe;
  logic [37:0] cur = 38'h00_0000_0000, v;
  int          n_fail = 0, num_checks = 0, cyc = 0;
  always #2 i_clk = ~i_clk;
  mbs_loop_model mbs_loop_model_i (.i_clk(i_clk), .i_active(act), .o_switch_event(sw),
    .o_softstart_request(ssreq));
  mbs_top mbs_top_i (.i_clk(i_clk), .i_srst(i_srst), .i_controller_enable(en),
    .i_bypass_pin(byp), .i_switch_event(sw), .i_softstart_request(ssreq),
    .i_cfg_serial_in(sin), .i_cfg_serial_clock(sclk), .i_cfg_apply(apply),
    .o_cfg_serial_out(so), .o_force_comp_high(fch), .o_ss_active(ssa), .o_ss_done(ssd),
    .o_forced_cont_mode_out(fco), .o_ton_sel(ton), .o_ext_ref(xref), .o_ref_trim(trim),
    .o_ref_sel(rsel), .o_ext_cap(xcap), .o_high_gm(hgm), .o_phase_drive(drv),
    .o_phase_drive_oe(oe), .o_phase_strobe(strobe), .o_debug_out(dbg));
  // Enabled-phase mask for a phase-count field
  function automatic logic [7:0] ph_mask(input logic [2:0] n);
    ph_mask = 8'hFF >> (3'h7 - n);
  endfunction : ph_mask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      print_verdict();
    end
  end
  task load(input logic [37:0] c);
    for (int i = 37; i >= 0; i--) begin
      @(negedge i_clk) sin = c[i];
      repeat (3) @(negedge i_clk);
      sclk = 1'b1;
      repeat (3) @(negedge i_clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    `CHK("serial out", c[37], so)
    `CHK("ton before apply", cur[13:10], ton)
    apply = 1'b1;
    repeat (3) @(negedge i_clk);
    apply = 1'b0;
    repeat (6) @(negedge i_clk);
    cur = c;
    `CHK("fields", {c[27:25], c[24:17], c[13:10], c[1]}, {hgm, xcap, rsel, trim, ton, xref})
  endtask : load
  task run_case(input logic [37:0] c);
    int np;
    load(c);
    np = c[16:14] + 1;
    en = 1'b1;
    repeat (12) @(negedge i_clk);
    `CHK("ss_done", 1'b1, ssd)
    `CHK("ccm pin", c[28], fco)
    `CHK("debug", {c[37:36] == 2'h1, c[35:34] != 2'h3}, dbg[3:2])
    act = 1'b1;
    if (c[28]) begin
      for (int k = 0; k < 2 * np; k++) begin
        repeat (40) begin
          @(posedge i_clk);
          #1;
          if (strobe === 1'b1) break;
        end
        `CHK("one-hot drive", 8'h01 << (k % np), drv)
      end
    end else begin
      repeat (40) @(negedge i_clk);
      `CHK("static drive", ph_mask(c[16:14]), drv)
    end
    en = 1'b0;
    act = 1'b0;
    repeat (6) @(negedge i_clk);
    `CHK("disabled", 11'h000, {fch, ssa, ssd, drv})
  endtask : run_case
  initial begin
    void'($urandom(32'h331bde3e));
    repeat (4) @(negedge i_clk);
    i_srst = 1'b0;
    `CHK("reset oe", 8'hFF, oe)
    `CHK("reset flags", 3'h0, {fch, ssa, ssd})
    en = 1'b1;
    repeat (10) @(negedge i_clk);
    `CHK("dead-time flags", 3'h4, {fch, ssa, ssd})
    en = 1'b0;
    repeat (6) @(negedge i_clk);
    byp = 1'b1;
    run_case(38'h00_3001_C000);
    byp = 1'b0;
    for (int i = 0; i < 6; i++) begin
      v = {$urandom, $urandom};
      v[0] = 1'b1;
      v[29] = 1'b1;
      v[28] = i[0];
      if (i < 2) v[16:14] = 3'h0;
      run_case(v);
    end
    print_verdict();
  end
endmodule : multiphase_buck_sequencer_tb_top
